// File: hw/lpmc_top.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps

// Function
// - IDLE2 halts CPU and watchdog, peripherals run, release returns to NORMAL2.
// - SLEEP1 keeps only low oscillator, halts CPU, watchdog; returns to SLOW1.
// - SLOW1 and SLEEP1 stop the clock into divider stage one.
// - SLEEP2 behaves as SLEEP1 but keeps the high oscillator running.
// - peripheral clock halt bit enters SLEEP0 from SLOW, IDLE0 from NORMAL; only time base keeps clocking.
// - SLEEP0 ends on time base source falling edge, resuming in SLOW1; the code resumes in SLOW2 when xen_reg is set.
// - SLEEP0 ignores time base enable; service needs master, irq enable, enable.
// - entering SLEEP0 with time base enabled sets time base latch on return.
// - STOP halts oscillators; stop pin event releases; warm-up, then resume.
// - writing bit 7 of stop control starts STOP.
// - bit 6 picks release: 0 edge, 1 level.
// - bit 5 picks return: 0 NORMAL, 1 SLOW1.
// - bit 4: 0 ports high impedance in STOP, 1 outputs kept.
// - two-bit field selects one of four warm-up lengths per return mode.
// - reset pin during STOP returns to NORMAL1 regardless of return mode.
// - bits 1 and 0 of stop control read undefined; the code reads them as zero.
// - STOP with port output bit 0 forces port inputs to zero.
// - stop pin goes high impedance in STOP regardless of port output bit.
// - CPU halt idle modes end on interrupt request; serviced if master set.
// - release from IDLE1, IDLE2, SLEEP1 or SLEEP2 clears the CPU halt bit.
module lpmc_top
    import lpmc_pkg::*;
#(
    parameter int warm_fc_unit = LPMC_WARM_FC_UNIT,
    parameter int warm_fs_long = LPMC_WARM_FS_LONG,
    parameter int warm_fs_short = LPMC_WARM_FS_SHORT
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire lpmc_bus_req_t bus,
    output logic [7:0] rdata,
    input wire logic fc_tick,
    input wire logic fs_tick,
    input wire logic irq_req,
    input wire logic interrupt_master_flag,
    input wire logic time_base_irq_enable,
    input wire logic time_base_enable,
    input wire logic time_base_source,
    input wire logic stop_pin_port_i,
    output logic stop_pin_port_o,
    output logic stop_pin_port_oe,
    input wire logic port_latch_value,
    input wire logic port_drive,
    output logic ports_output_en,
    output logic port_input_force_zero,
    output lpmc_state_t mode,
    output lpmc_clk_en_t clk_en,
    output lpmc_evt_t evt
);

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    lpmc_state_t state_reg, state_next, run_target;
    logic stop_start_reg, release_method_reg, return_mode_reg;
    logic stop_port_output_reg;
    logic [1:0] warmup_select_reg;
    logic xen_reg, xten_reg, sysck_reg, cpu_halt_reg, pclk_halt_reg;
    logic tb_at_entry_reg;
    logic [LPMC_WARM_W-1:0] warm_cnt_reg;
    logic [7:0] rdata_reg;
    logic stop_meta_reg, stop_sync_reg, stop_prev_reg;
    logic tb_meta_reg, tb_sync_reg, tb_prev_reg;
    lpmc_clk_en_t clk_en_reg;
    lpmc_evt_t evt_reg;
    logic pin_o_reg, pin_oe_reg, ports_oe_reg, force_zero_reg;
    logic wr_stop, wr_sys2, in_run, in_halt, halt_release, tb_fall;
    logic stop_release, warm_tick, enter_warm, warm_exit, sleep0_exit;

    function automatic logic is_run(input lpmc_state_t s);
        return s inside {ST_NORMAL1, ST_NORMAL2, ST_SLOW1, ST_SLOW2};
    endfunction

    function automatic logic in_stop_period(input lpmc_state_t s);
        return s inside {ST_STOP, ST_WARMUP};
    endfunction

    function automatic lpmc_state_t halt_of(input lpmc_state_t s);
        unique case (s)
            ST_NORMAL2: return ST_IDLE2;
            ST_SLOW2: return ST_SLEEP2;
            ST_SLOW1: return ST_SLEEP1;
            default: return ST_IDLE1;
        endcase
    endfunction

    function automatic logic [LPMC_WARM_W-1:0] warm_len(
        input logic [1:0] sel,
        input logic to_slow
    );
        logic [LPMC_WARM_W-1:0] u;
        u = LPMC_WARM_W'(warm_fc_unit);
        if (to_slow)
        begin
            unique case (sel)
                2'h0: return LPMC_WARM_W'(3 * warm_fs_long);
                2'h1: return LPMC_WARM_W'(warm_fs_long);
                2'h2: return LPMC_WARM_W'(3 * warm_fs_short);
                default: return LPMC_WARM_W'(warm_fs_short);
            endcase
        end
        unique case (sel)
            2'h0: return LPMC_WARM_W'(12 * warm_fc_unit);
            2'h1: return LPMC_WARM_W'(4 * warm_fc_unit);
            2'h2: return LPMC_WARM_W'(3 * warm_fc_unit);
            default: return u;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            stop_meta_reg <= 1'b0;
            stop_sync_reg <= 1'b0;
            stop_prev_reg <= 1'b0;
            tb_meta_reg <= 1'b0;
            tb_sync_reg <= 1'b0;
            tb_prev_reg <= 1'b0;
        end
        else
        begin
            stop_meta_reg <= stop_pin_port_i;
            stop_sync_reg <= stop_meta_reg;
            stop_prev_reg <= stop_sync_reg;
            tb_meta_reg <= time_base_source;
            tb_sync_reg <= tb_meta_reg;
            tb_prev_reg <= tb_sync_reg;
        end
    end

    assign wr_stop = bus.wr && bus.addr == LPMC_ADDR_STOP_CTRL;
    assign wr_sys2 = bus.wr && bus.addr == LPMC_ADDR_SYS_CTRL2;
    assign in_run = is_run(state_reg);
    assign in_halt = state_reg inside {ST_IDLE1, ST_IDLE2, ST_SLEEP1,
                                       ST_SLEEP2};
    assign tb_fall = tb_prev_reg && !tb_sync_reg;
    assign halt_release = in_halt && irq_req;
    assign sleep0_exit = state_reg inside {ST_IDLE0, ST_SLEEP0} && tb_fall;
    // level mode releases on a high pin, edge mode on a rising edge
    assign stop_release = release_method_reg ? stop_sync_reg
                        : (stop_sync_reg && !stop_prev_reg);
    assign warm_tick = return_mode_reg ? fs_tick : fc_tick;
    assign enter_warm = state_next == ST_WARMUP && state_reg != ST_WARMUP;
    assign warm_exit = state_reg == ST_WARMUP && warm_cnt_reg == '0;

    // ----------------------------------------------------------------
    // mode sequencing
    // ----------------------------------------------------------------
    always_comb
    begin
        if (sysck_reg)
            run_target = xen_reg ? ST_SLOW2 : ST_SLOW1;
        else
            run_target = xten_reg ? ST_NORMAL2 : ST_NORMAL1;
        state_next = state_reg;
        unique case (state_reg)
            ST_NORMAL1, ST_NORMAL2, ST_SLOW1, ST_SLOW2:
            begin
                if (stop_start_reg)
                    // a high pin in level mode skips straight to warm-up
                    state_next = (release_method_reg && stop_sync_reg)
                               ? ST_WARMUP : ST_STOP;
                else if (pclk_halt_reg)
                    state_next = sysck_reg ? ST_SLEEP0 : ST_IDLE0;
                else if (cpu_halt_reg)
                    state_next = halt_of(run_target);
                else
                    state_next = run_target;
            end
            ST_IDLE1, ST_IDLE2, ST_SLEEP1, ST_SLEEP2:
            begin
                if (halt_release)
                    state_next = run_target;
            end
            ST_IDLE0, ST_SLEEP0:
            begin
                if (tb_fall)
                    state_next = run_target;
            end
            ST_STOP:
            begin
                if (stop_release)
                    state_next = ST_WARMUP;
            end
            ST_WARMUP:
            begin
                if (warm_exit)
                    state_next = return_mode_reg ? ST_SLOW1
                               : (xten_reg ? ST_NORMAL2 : ST_NORMAL1);
            end
            default: state_next = ST_NORMAL1;
        endcase
    end

    // reset, including one during STOP, always lands in NORMAL1
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            state_reg <= ST_NORMAL1;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            warm_cnt_reg <= '0;
        else if (enter_warm)
            warm_cnt_reg <= warm_len(warmup_select_reg,
                                     return_mode_reg);
        else if (state_reg == ST_WARMUP && warm_tick && warm_cnt_reg != '0)
            warm_cnt_reg <= warm_cnt_reg - 1'b1;
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            stop_start_reg <= LPMC_STOP_CTRL_RST[LPMC_STOP_START_BIT];
            release_method_reg <= LPMC_STOP_CTRL_RST[LPMC_RELEASE_METHOD_BIT];
            return_mode_reg <= LPMC_STOP_CTRL_RST[LPMC_RETURN_MODE_BIT];
            stop_port_output_reg <= LPMC_STOP_CTRL_RST[LPMC_PORT_OUTPUT_BIT];
            warmup_select_reg <= LPMC_STOP_CTRL_RST[LPMC_WARMUP_HI_BIT:
                                                    LPMC_WARMUP_LO_BIT];
        end
        else if (wr_stop)
        begin
            stop_start_reg <= bus.wdata[LPMC_STOP_START_BIT];
            release_method_reg <= bus.wdata[LPMC_RELEASE_METHOD_BIT];
            return_mode_reg <= bus.wdata[LPMC_RETURN_MODE_BIT];
            stop_port_output_reg <= bus.wdata[LPMC_PORT_OUTPUT_BIT];
            warmup_select_reg <= bus.wdata[LPMC_WARMUP_HI_BIT:
                                           LPMC_WARMUP_LO_BIT];
        end
        else if (warm_exit)
            stop_start_reg <= 1'b0;
    end

    // a software write in the release cycle wins over the hardware clear
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            xen_reg <= LPMC_SYS_CTRL2_RST[LPMC_XEN_BIT];
            xten_reg <= LPMC_SYS_CTRL2_RST[LPMC_XTEN_BIT];
            sysck_reg <= LPMC_SYS_CTRL2_RST[LPMC_SYSCK_BIT];
            cpu_halt_reg <= LPMC_SYS_CTRL2_RST[LPMC_CPU_HALT_BIT];
            pclk_halt_reg <= LPMC_SYS_CTRL2_RST[LPMC_PCLK_HALT_BIT];
        end
        else if (wr_sys2)
        begin
            xen_reg <= bus.wdata[LPMC_XEN_BIT];
            xten_reg <= bus.wdata[LPMC_XTEN_BIT];
            sysck_reg <= bus.wdata[LPMC_SYSCK_BIT];
            cpu_halt_reg <= bus.wdata[LPMC_CPU_HALT_BIT];
            pclk_halt_reg <= bus.wdata[LPMC_PCLK_HALT_BIT];
        end
        else
        begin
            if (halt_release)
                cpu_halt_reg <= 1'b0;
            if (sleep0_exit)
                pclk_halt_reg <= 1'b0;
            if (warm_exit)
            begin
                sysck_reg <= return_mode_reg;
                xen_reg <= !return_mode_reg;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            tb_at_entry_reg <= 1'b0;
        else if (in_run && state_next inside {ST_IDLE0, ST_SLEEP0})
            tb_at_entry_reg <= time_base_enable;
    end

    // undefined low bits of stop control read as zero
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rdata_reg <= 8'h00;
        else if (bus.rd && bus.addr == LPMC_ADDR_STOP_CTRL)
            rdata_reg <= {stop_start_reg, release_method_reg,
                          return_mode_reg, stop_port_output_reg,
                          warmup_select_reg, 2'h0};
        else if (bus.rd && bus.addr == LPMC_ADDR_SYS_CTRL2)
            rdata_reg <= {xen_reg, xten_reg, sysck_reg, cpu_halt_reg,
                          1'b0, pclk_halt_reg, 2'h0};
        else if (bus.rd)
            rdata_reg <= 8'h00;
    end

    // ----------------------------------------------------------------
    // clock gating, pins and events
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            clk_en_reg <= '{cpu: 1'b1, wdt: 1'b1, periph: 1'b1, time_base_timer: 1'b1,
                            div_first: 1'b1, hf_osc: 1'b1, lf_osc: 1'b0,
                            main_low: 1'b0};
            pin_o_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
            ports_oe_reg <= 1'b1;
            force_zero_reg <= 1'b0;
        end
        else
        begin
            clk_en_reg.cpu <= is_run(state_next);
            clk_en_reg.wdt <= is_run(state_next);
            clk_en_reg.periph <= !(state_next inside {ST_IDLE0, ST_SLEEP0})
                                 && !in_stop_period(state_next);
            clk_en_reg.time_base_timer <= !in_stop_period(state_next);
            clk_en_reg.div_first <= !(state_next inside {ST_SLOW1,
                                      ST_SLEEP1, ST_SLEEP2})
                                    && !in_stop_period(state_next);
            // warm-up restarts the oscillator of the return mode, and the low one too if xten_reg is set
            clk_en_reg.hf_osc <= (state_next == ST_WARMUP) ? !return_mode_reg
                                 : (state_next != ST_STOP && xen_reg);
            clk_en_reg.lf_osc <= (state_next == ST_WARMUP)
                                 ? (return_mode_reg || xten_reg)
                                 : (state_next != ST_STOP && xten_reg);
            clk_en_reg.main_low <= sysck_reg;
            pin_o_reg <= port_latch_value;
            pin_oe_reg <= port_drive
                          && !in_stop_period(state_next);
            ports_oe_reg <= !in_stop_period(state_next)
                            || stop_port_output_reg;
            force_zero_reg <= in_stop_period(state_next)
                              && !stop_port_output_reg;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            evt_reg <= '0;
        else
        begin
            evt_reg.resume <= halt_release || sleep0_exit || warm_exit;
            evt_reg.irq_service <= halt_release
                                   && interrupt_master_flag;
            evt_reg.tbt_latch_set <= sleep0_exit && tb_at_entry_reg;
            evt_reg.tbt_irq_service <= sleep0_exit && interrupt_master_flag
                                       && time_base_irq_enable
                                       && time_base_enable;
            evt_reg.div_clear <= (in_run && in_stop_period(state_next))
                                 || (state_reg == ST_STOP && stop_release);
        end
    end

    assign rdata = rdata_reg;
    assign mode = state_reg;
    assign clk_en = clk_en_reg;
    assign evt = evt_reg;
    assign stop_pin_port_o = pin_o_reg;
    assign stop_pin_port_oe = pin_oe_reg;
    assign ports_output_en = ports_oe_reg;
    assign port_input_force_zero = force_zero_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence edge_stop_write_s;
        wr_stop && bus.wdata[LPMC_STOP_START_BIT]
        && !bus.wdata[LPMC_RELEASE_METHOD_BIT] && in_run;
    endsequence

    sequence warm_done_s;
        state_reg == ST_WARMUP && warm_cnt_reg == '0;
    endsequence

    stop_start_a: assert property (edge_stop_write_s |-> ##2
        state_reg == ST_STOP && !clk_en.cpu && !clk_en.hf_osc)
        else $error("stop write did not reach STOP");
    stop_pin_hiz_a: assert property (state_reg == ST_STOP
        |-> !stop_pin_port_oe)
        else $error("stop pin driven in STOP");
    port_hold_a: assert property (state_reg == ST_STOP
        |-> ports_output_en == stop_port_output_reg
            && port_input_force_zero == !stop_port_output_reg)
        else $error("port output state wrong in STOP");
    sleep0_wake_a: assert property (state_reg == ST_SLEEP0 && tb_fall
        |=> state_reg == $past(run_target) && !pclk_halt_reg)
        else $error("SLEEP0 not left on time base edge");
    halt_clear_a: assert property (halt_release && !wr_sys2
        |=> !cpu_halt_reg && clk_en.cpu)
        else $error("halt bit not cleared on release");
    div_stop_a: assert property (state_reg inside {ST_SLOW1, ST_SLEEP1}
        |-> !clk_en.div_first)
        else $error("divider stage one clocked in SLOW1 or SLEEP1");
    sleep1_clk_a: assert property (state_reg == ST_SLEEP1
        |-> !clk_en.cpu && !clk_en.wdt && !clk_en.hf_osc
            && clk_en.periph)
        else $error("SLEEP1 clock set wrong");
    warm_cpu_a: assert property (state_reg == ST_WARMUP
        |-> !clk_en.cpu)
        else $error("CPU clocked during warm-up");
    edge_release_a: assert property (state_reg == ST_STOP
        && !release_method_reg && stop_sync_reg && !stop_prev_reg
        |=> state_reg == ST_WARMUP)
        else $error("edge release missed");
    return_slow_a: assert property (warm_done_s ##0 return_mode_reg[*1]
        |=> state_reg == ST_SLOW1 ##1 clk_en.cpu)
        else $error("return to SLOW1 missed");

endmodule

// File: hw/lpmc_pkg.sv
package lpmc_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [15:0] LPMC_ADDR_STOP_CTRL = 16'h0038;
    localparam logic [15:0] LPMC_ADDR_SYS_CTRL2 = 16'h0039;

    // stop_mode_control fields
    localparam int LPMC_STOP_START_BIT = 7;
    localparam int LPMC_RELEASE_METHOD_BIT = 6;
    localparam int LPMC_RETURN_MODE_BIT = 5;
    localparam int LPMC_PORT_OUTPUT_BIT = 4;
    localparam int LPMC_WARMUP_HI_BIT = 3;
    localparam int LPMC_WARMUP_LO_BIT = 2;

    // system_control_two fields
    localparam int LPMC_XEN_BIT = 7;
    localparam int LPMC_XTEN_BIT = 6;
    localparam int LPMC_SYSCK_BIT = 5;
    localparam int LPMC_CPU_HALT_BIT = 4;
    localparam int LPMC_PCLK_HALT_BIT = 2;

    // values after reset
    localparam logic [7:0] LPMC_STOP_CTRL_RST = 8'h00;
    localparam logic [7:0] LPMC_SYS_CTRL2_RST = 8'h80;

    // warm-up lengths in oscillator ticks
    localparam int LPMC_WARM_W = 18;
    localparam int LPMC_WARM_FC_UNIT = 16384;
    localparam int LPMC_WARM_FS_LONG = 8192;
    localparam int LPMC_WARM_FS_SHORT = 64;

    // ----------------------------------------------------------------
    // operating modes
    // ----------------------------------------------------------------
    typedef enum logic [11:0] {
        ST_NORMAL1 = 12'h001,
        ST_NORMAL2 = 12'h002,
        ST_SLOW2 = 12'h004,
        ST_SLOW1 = 12'h008,
        ST_IDLE1 = 12'h010,
        ST_IDLE2 = 12'h020,
        ST_SLEEP2 = 12'h040,
        ST_SLEEP1 = 12'h080,
        ST_IDLE0 = 12'h100,
        ST_SLEEP0 = 12'h200,
        ST_STOP = 12'h400,
        ST_WARMUP = 12'h800
    } lpmc_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lpmc_bus_req_t;

    typedef struct packed {
        logic cpu;
        logic wdt;
        logic periph;
        logic time_base_timer;
        logic div_first;
        logic hf_osc;
        logic lf_osc;
        logic main_low;
    } lpmc_clk_en_t;

    typedef struct packed {
        logic resume;
        logic irq_service;
        logic tbt_latch_set;
        logic tbt_irq_service;
        logic div_clear;
    } lpmc_evt_t;

endpackage

// File: verif/lpmc_partner.sv
`timescale 1ns/1ps
// ----
// oscillator ticks, stop pin and time base source
// ----
module lpmc_partner
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic pin_hi,
    input wire logic tb_level,
    output logic fc_tick,
    output logic fs_tick,
    output logic stop_pin_port_i,
    output logic time_base_source
);
    logic [1:0] div_reg;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            div_reg <= 2'h0;
        else
            div_reg <= div_reg + 2'h1;
    end
    // fs is half the fc rate, so the two warm-up paths cannot alias
    assign fc_tick = div_reg[0];
    assign fs_tick = &div_reg;
    // pin follows pin_hi directly: low unless the testbench raises it
    assign stop_pin_port_i = pin_hi;
    assign time_base_source = tb_level;
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench
    import lpmc_pkg::*;
;
    localparam int FCU = 4;
    localparam int FSL = 4;
    localparam int FSS = 2;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic irq_req = 1'b0;
    logic interrupt_master_flag = 1'b1;
    logic time_base_irq_enable = 1'b1;
    logic time_base_enable = 1'b0;
    logic pin_hi = 1'b0;
    logic tb_level = 1'b1;
    logic port_latch_value = 1'b0;
    logic port_drive = 1'b1;
    lpmc_bus_req_t bus = '0;
    logic fc_tick, fs_tick, time_base_source, stop_pin_port_i, o;
    logic stop_pin_port_o, stop_pin_port_oe, ports_output_en;
    logic port_input_force_zero;
    logic [7:0] rdata, v;
    lpmc_state_t mode;
    lpmc_clk_en_t clk_en;
    lpmc_evt_t evt;
    int failures = 0;
    int comparisons = 0;
    int seed = 54;
    int cycles = 0;
    int n_latch = 0;
    int n_svc = 0;
    int n_irs = 0;
    int e_irs = 0;
    int n_res = 0;
    int n_fc, n_fs, k, n, t;
    logic [7:0] bases [4] = '{8'h80, 8'hc0, 8'he0, 8'h60};
    lpmc_state_t runs [4] = '{ST_NORMAL1, ST_NORMAL2, ST_SLOW2, ST_SLOW1};
    lpmc_state_t idles [4] = '{ST_IDLE1, ST_IDLE2, ST_SLEEP2, ST_SLEEP1};

    initial
        forever #2.5 mclk = ~mclk;
    lpmc_partner partner (.*);
    lpmc_top #(.warm_fc_unit(FCU), .warm_fs_long(FSL), .warm_fs_short(FSS))
        dut (.*);

    // ----
    // shared tasks
    // ----
    task automatic end_sim;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({11'h0, got}, {11'h0, exp});
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        @(negedge mclk);
        chk({4'h0, rdata}, {4'h0, e});
        @(posedge mclk);
    endtask
    task automatic wait_mode(input lpmc_state_t m, input int lim);
        int i;
        @(negedge mclk);
        for (i = 0; i < lim && mode !== m; i++)
            @(negedge mclk);
        chk(mode, m);
        @(posedge mclk);
    endtask
    // counts sampled before the edge's updates, as the design sees them
    always @(posedge mclk)
    begin
        cycles++;
        n_latch += (evt.tbt_latch_set === 1'b1);
        n_svc += (evt.tbt_irq_service === 1'b1);
        n_irs += (evt.irq_service === 1'b1);
        n_res += (evt.resume === 1'b1);
        n_fc += (mode === ST_WARMUP && fc_tick === 1'b1);
        n_fs += (mode === ST_WARMUP && fs_tick === 1'b1);
        if (cycles == 6000)
        begin
            failures++;
            end_sim();
        end
    end

    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        port_latch_value <= 1'($random(seed));
        wait_mode(ST_NORMAL1, 1);
        rd(LPMC_ADDR_STOP_CTRL, LPMC_STOP_CTRL_RST);
        chk1(stop_pin_port_o, port_latch_value);
        rd(LPMC_ADDR_SYS_CTRL2, LPMC_SYS_CTRL2_RST);
        rd(16'h0040, 8'h00);
        repeat (4)
        begin
            v = 8'($random(seed)) & 8'h7f;
            wr(LPMC_ADDR_STOP_CTRL, v);
            rd(LPMC_ADDR_STOP_CTRL, v & 8'h7c);
        end
        for (k = 0; k < 4; k++)
        begin
            wr(LPMC_ADDR_SYS_CTRL2, bases[k]);
            wait_mode(runs[k], 2);
            wr(LPMC_ADDR_SYS_CTRL2, bases[k] | 8'h10);
            wait_mode(idles[k], 2);
            chk1(clk_en.cpu | clk_en.wdt, 1'b0);
            chk1(clk_en.periph, 1'b1);
            chk1(clk_en.hf_osc, bases[k][7]);
            chk1(clk_en.div_first, !bases[k][5]);
            chk1(clk_en.main_low, bases[k][5]);
            o = 1'($random(seed));
            e_irs += o;
            interrupt_master_flag <= o;
            irq_req <= 1'b1;
            @(posedge mclk);
            irq_req <= 1'b0;
            wait_mode(runs[k], 3);
            rd(LPMC_ADDR_SYS_CTRL2, bases[k]);
        end
        chk(12'(n_irs), 12'(e_irs));
        interrupt_master_flag <= 1'b1;
        for (k = 0; k < 2; k++)
        begin
            time_base_enable <= (k == 0);
            wr(LPMC_ADDR_SYS_CTRL2, 8'h64);
            wait_mode(ST_SLEEP0, 2);
            chk({10'h0, clk_en.periph, clk_en.time_base_timer}, 12'h001);
            tb_level <= 1'b0;
            wait_mode(ST_SLOW1, 8);
            tb_level <= 1'b1;
            rd(LPMC_ADDR_SYS_CTRL2, 8'h60);
        end
        chk(12'(n_latch), 12'h001);
        chk(12'(n_svc), 12'h001);
        for (k = 0; k < 8; k++)
        begin
            wr(LPMC_ADDR_SYS_CTRL2, k[2] ? 8'h60 : 8'h80);
            o = 1'($random(seed));
            v = {1'b1, k[1:0] == 2'h3, k[2], o, k[1:0], 2'h0};
            pin_hi <= v[6];
            n_fc = 0;
            n_fs = 0;
            wr(LPMC_ADDR_STOP_CTRL, v);
            wait_mode(v[6] ? ST_WARMUP : ST_STOP, 2);
            chk1(stop_pin_port_oe | clk_en.cpu, 1'b0);
            chk1(ports_output_en, o);
            chk1(port_input_force_zero, !o);
            pin_hi <= 1'b1;
            wait_mode(ST_WARMUP, 6);
            wait_mode(k[2] ? ST_SLOW1 : ST_NORMAL1, 120);
            pin_hi <= 1'b0;
            n = k[2] ? (k[1] ? FSS : FSL) : (k[1] ? FCU : 4 * FCU);
            n = k[0] ? n : 3 * n;
            t = k[2] ? n_fs : n_fc;
            chk1(t >= n && t <= n + 1, 1'b1);
            rd(LPMC_ADDR_STOP_CTRL, v & 8'h7c);
        end
        chk(12'(n_res), 12'h00e);
        wr(LPMC_ADDR_STOP_CTRL, 8'ha0);
        wait_mode(ST_STOP, 2);
        resetn <= 1'b0;
        @(posedge mclk);
        resetn <= 1'b1;
        wait_mode(ST_NORMAL1, 2);
        end_sim();
    end
endmodule
